// file: hdl/smc_pkg.sv
// constants and types for the system management mode save-map control
package smc_pkg;

  // save-map offsets relative to the private memory base
  localparam logic [31:0] BASE_FIELD_OFF   = 32'h0000_7EF8;
  localparam logic [31:0] REV_ID_OFF       = 32'h0000_7EFC;
  localparam logic [31:0] HALT_WORD_OFF    = 32'h0000_7F00;
  localparam logic [31:0] HALT_FIELD_OFF   = 32'h0000_7F02;
  localparam logic [31:0] HANDLER_OFF      = 32'h0000_8000;
  localparam logic [31:0] SAVE_LO_OFF      = 32'h0000_FE00;
  localparam logic [31:0] SAVE_HI_OFF      = 32'h0000_FFFF;

  // reset value of the internal base register
  localparam logic [31:0] BASE_RESET       = 32'h0003_0000;

  // field positions
  localparam int          REV_IO_RESTART_BIT = 16;
  localparam int          REV_RELOC_BIT      = 17;
  localparam int          HALT_FLAG_BIT      = 0;
  localparam int          HALT_LANE_SHIFT    = 16;
  localparam int          SEG_SHIFT          = 4;
  localparam logic [31:0] ALIGN_MASK         = 32'h0000_7FFF;

  // byte enables for a full word and the upper half word
  localparam logic [3:0]  BE_WORD          = 4'hF;
  localparam logic [3:0]  BE_UPPER_HALF    = 4'hC;

  // arbitrary neutral base architecture version
  localparam logic [15:0] REV_BASE_VERSION = 16'h0001;

  // controller states, gray coded along entry, run and resume up to commit; commit back to idle changes two bits
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_WR_REV   = 4'h1,
    ST_WR_HALT  = 4'h3,
    ST_RUN      = 4'h2,
    ST_RD_BASE  = 4'h6,
    ST_RD_HALT  = 4'h7,
    ST_COMMIT   = 4'h5,
    ST_SHUTDOWN = 4'h4,
    ST_SMM_HALT = 4'hA
  } smc_state_t;

  // what the core does after the resume instruction
  typedef enum logic [1:0] {
    ACT_NEXT_INSTR = 2'h0,
    ACT_AFTER_HALT = 2'h1,
    ACT_HALT_AGAIN = 2'h2
  } smc_action_t;

endpackage

// file: hdl/smc_addr.sv
// address forming for handler entry, save area and real-mode segments
`timescale 1ns/100ps
module smc_addr (
  // base and access
  input  wire logic [31:0] i_base,
  input  wire logic [15:0] i_seg,
  input  wire logic [31:0] i_offset,
  input  wire logic        i_addr32,
  // results
  output logic      [31:0] o_handler_addr,
  output logic      [31:0] o_save_lo,
  output logic      [31:0] o_save_hi,
  output logic      [31:0] o_linear_addr
);

  logic [19:0] seg_base;

  assign o_handler_addr = i_base + smc_pkg::HANDLER_OFF;
  assign o_save_lo      = i_base + smc_pkg::SAVE_LO_OFF;
  assign o_save_hi      = i_base + smc_pkg::SAVE_HI_OFF;
  // segment base limited to 20 bits
  assign seg_base       = {i_seg, 4'h0};
  // 32-bit override reaches above 1 MByte with zero segment bases
  assign o_linear_addr  = i_addr32 ? ({12'h000, seg_base} + i_offset)
                                   : {12'h000, seg_base + {4'h0, i_offset[15:0]}};

endmodule

// file: hdl/smc_control.sv
// system management mode entry, save-map update and resume control
`timescale 1ns/100ps
module smc_control #(
  parameter logic LEGACY_ALIGN = 1'b0,
  parameter logic IO_RESTART   = 1'b1,
  parameter logic BASE_RELOC   = 1'b1
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // core events
  input  wire logic        i_smi_req,
  input  wire logic        i_intr_req,
  input  wire logic        i_soft_init,
  input  wire logic        i_halted,
  input  wire logic        i_halt_exec,
  input  wire logic        i_resume,
  // real-mode address forming
  input  wire logic [15:0] i_seg,
  input  wire logic [31:0] i_offset,
  input  wire logic        i_addr32,
  // save-map memory port
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic      [31:0] o_mem_addr,
  output logic      [31:0] o_mem_wdata,
  output logic      [3:0]  o_mem_be,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  // mode status
  output logic             o_in_smm,
  output logic             o_smm_halted,
  output logic             o_shutdown,
  output logic             o_fpu_real16,
  output logic             o_entry,
  output logic      [31:0] o_handler_addr,
  output logic      [31:0] o_save_lo,
  output logic      [31:0] o_save_hi,
  output logic      [31:0] o_linear_addr,
  output logic      [31:0] o_base,
  // resume outcome
  output logic             o_resume,
  output logic      [1:0]  o_resume_action,
  output logic             o_halt_refetch
);

  typedef struct packed {
    smc_pkg::smc_state_t st;
    logic [31:0]         base;
    logic [31:0]         new_base;
    logic                halted_at_entry;
    logic                halt_flag;
    logic [1:0]          smi_sync;
    logic [1:0]          intr_sync;
    logic                mem_req;
    logic                mem_we;
    logic [31:0]         mem_addr;
    logic [31:0]         mem_wdata;
    logic [3:0]          mem_be;
    logic                entry;
    logic                resume;
    smc_pkg::smc_action_t action;
  } smc_regs_t;

  localparam smc_regs_t REGS_RESET = '{
    st: smc_pkg::ST_IDLE, base: smc_pkg::BASE_RESET, new_base: 32'h0000_0000,
    halted_at_entry: 1'b0, halt_flag: 1'b0, smi_sync: 2'h0, intr_sync: 2'h0,
    mem_req: 1'b0, mem_we: 1'b0, mem_addr: 32'h0000_0000, mem_wdata: 32'h0000_0000,
    mem_be: 4'h0, entry: 1'b0, resume: 1'b0, action: smc_pkg::ACT_NEXT_INSTR};

  localparam logic [31:0] REV_ID = {14'h0000, BASE_RELOC, IO_RESTART,
                                    smc_pkg::REV_BASE_VERSION};

  smc_regs_t r;
  smc_regs_t next_r;
  logic      misaligned;

  assign misaligned = LEGACY_ALIGN && ((r.new_base & smc_pkg::ALIGN_MASK) != 32'h0000_0000);

  always_comb begin
    next_r           = r;
    next_r.smi_sync  = {r.smi_sync[0], i_smi_req};
    next_r.intr_sync = {r.intr_sync[0], i_intr_req};
    next_r.entry     = 1'b0;
    next_r.resume    = 1'b0;
    case (r.st)
      smc_pkg::ST_IDLE: begin
        if (r.smi_sync[1]) begin
          next_r.st              = smc_pkg::ST_WR_REV;
          next_r.halted_at_entry = i_halted;
          next_r.mem_req         = 1'b1;
          next_r.mem_we          = 1'b1;
          next_r.mem_addr        = r.base + smc_pkg::REV_ID_OFF;
          next_r.mem_wdata       = REV_ID;
          next_r.mem_be          = smc_pkg::BE_WORD;
        end
      end
      smc_pkg::ST_WR_REV: begin
        if (i_mem_ack) begin
          next_r.st        = smc_pkg::ST_WR_HALT;
          next_r.mem_addr  = r.base + smc_pkg::HALT_WORD_OFF;
          // halt field sits in the upper half of its word
          next_r.mem_wdata = 32'({15'h0000, r.halted_at_entry}
                                 << smc_pkg::HALT_LANE_SHIFT);
          next_r.mem_be    = smc_pkg::BE_UPPER_HALF;
        end
      end
      smc_pkg::ST_WR_HALT: begin
        if (i_mem_ack) begin
          next_r.st      = smc_pkg::ST_RUN;
          next_r.mem_req = 1'b0;
          next_r.mem_we  = 1'b0;
          next_r.entry   = 1'b1;
        end
      end
      smc_pkg::ST_RUN: begin
        if (i_resume) begin
          next_r.st       = smc_pkg::ST_RD_BASE;
          next_r.mem_req  = 1'b1;
          next_r.mem_we   = 1'b0;
          next_r.mem_addr = r.base + smc_pkg::BASE_FIELD_OFF;
          next_r.mem_be   = smc_pkg::BE_WORD;
        end else if (i_halt_exec) begin
          next_r.st = smc_pkg::ST_SMM_HALT;
        end
      end
      smc_pkg::ST_SMM_HALT: begin
        if (r.intr_sync[1]) begin
          next_r.st = smc_pkg::ST_RUN;
        end
      end
      smc_pkg::ST_RD_BASE: begin
        if (i_mem_ack) begin
          next_r.st       = smc_pkg::ST_RD_HALT;
          next_r.new_base = i_mem_rdata;
          next_r.mem_addr = r.base + smc_pkg::HALT_WORD_OFF;
          next_r.mem_be   = smc_pkg::BE_UPPER_HALF;
        end
      end
      smc_pkg::ST_RD_HALT: begin
        if (i_mem_ack) begin
          next_r.st        = smc_pkg::ST_COMMIT;
          next_r.halt_flag = i_mem_rdata[smc_pkg::HALT_LANE_SHIFT + smc_pkg::HALT_FLAG_BIT];
          next_r.mem_req   = 1'b0;
        end
      end
      smc_pkg::ST_COMMIT: begin
        if (misaligned) begin
          next_r.st = smc_pkg::ST_SHUTDOWN;
        end else begin
          next_r.st     = smc_pkg::ST_IDLE;
          next_r.base   = r.new_base;
          next_r.resume = 1'b1;
          // a 0 to 1 change by the handler is treated as a plain return
          if (r.halted_at_entry && r.halt_flag) begin
            next_r.action = smc_pkg::ACT_HALT_AGAIN;
          end else if (r.halted_at_entry) begin
            next_r.action = smc_pkg::ACT_AFTER_HALT;
          end else begin
            next_r.action = smc_pkg::ACT_NEXT_INSTR;
          end
        end
      end
      smc_pkg::ST_SHUTDOWN: begin
        next_r.st = smc_pkg::ST_SHUTDOWN;
      end
      default: begin
        next_r.st = smc_pkg::ST_IDLE;
      end
    endcase
    // soft init aborts everything but keeps the base register
    if (i_soft_init) begin
      next_r      = REGS_RESET;
      next_r.base = r.base;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  smc_addr u_addr (
    .i_base         (r.base),
    .i_seg          (i_seg),
    .i_offset       (i_offset),
    .i_addr32       (i_addr32),
    .o_handler_addr (o_handler_addr),
    .o_save_lo      (o_save_lo),
    .o_save_hi      (o_save_hi),
    .o_linear_addr  (o_linear_addr)
  );

  assign o_mem_req       = r.mem_req;
  assign o_mem_we        = r.mem_we;
  assign o_mem_addr      = r.mem_addr;
  assign o_mem_wdata     = r.mem_wdata;
  assign o_mem_be        = r.mem_be;
  assign o_in_smm        = (r.st != smc_pkg::ST_IDLE) && (r.st != smc_pkg::ST_SHUTDOWN);
  assign o_smm_halted    = (r.st == smc_pkg::ST_SMM_HALT);
  assign o_shutdown      = (r.st == smc_pkg::ST_SHUTDOWN);
  assign o_fpu_real16    = o_in_smm;
  assign o_entry         = r.entry;
  assign o_base          = r.base;
  assign o_resume        = r.resume;
  assign o_resume_action = r.action;
  assign o_halt_refetch  = r.resume && (r.action == smc_pkg::ACT_HALT_AGAIN);

  a_entry_rev_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == smc_pkg::ST_IDLE && r.smi_sync[1] && !i_soft_init) |=>
    (o_mem_req && o_mem_we && o_mem_addr == $past(r.base) + smc_pkg::REV_ID_OFF))
    else $error("revision identifier not written at entry");

  a_rev_flag_bits: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == smc_pkg::ST_WR_REV) |->
    (o_mem_wdata[17:16] == {BASE_RELOC, IO_RESTART}))
    else $error("revision flag bits wrong");

  a_halt_flag_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == smc_pkg::ST_WR_HALT) |->
    (o_mem_wdata[16] == r.halted_at_entry && o_mem_be == 4'hC && o_mem_we))
    else $error("halt restart flag written wrong");

  a_halt_again_act: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == smc_pkg::ST_COMMIT && !misaligned && r.halted_at_entry && r.halt_flag
     && !i_soft_init) |=> (o_resume && o_halt_refetch))
    else $error("halt not restarted");

  a_next_instr_act: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_resume && !$past(r.halted_at_entry)) |->
    (o_resume_action == smc_pkg::ACT_NEXT_INSTR))
    else $error("plain return action wrong");

  a_smm_halt_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_smm_halted && !r.intr_sync[1] && !i_soft_init) |=> o_smm_halted)
    else $error("left halt without interrupt");

  a_soft_init_base: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_soft_init |=> (r.base == $past(r.base) && r.st == smc_pkg::ST_IDLE))
    else $error("soft init changed base");

  a_reset_base: assert property (@(posedge i_clock)
    !i_rst_n |=> (r.base == smc_pkg::BASE_RESET))
    else $error("reset did not restore base");

  a_base_reload: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == smc_pkg::ST_COMMIT && !misaligned && !i_soft_init) |=>
    (r.base == $past(r.new_base) && o_resume))
    else $error("base not reloaded at resume");

  a_handler_entry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_entry |-> (o_handler_addr == r.base + smc_pkg::HANDLER_OFF))
    else $error("handler address wrong");

  a_legacy_shutdown: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == smc_pkg::ST_COMMIT && misaligned && !i_soft_init) |=>
    (o_shutdown && !o_resume))
    else $error("misaligned base did not shut down");

  a_read_before_go: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == smc_pkg::ST_RUN && i_resume && !i_soft_init) |=>
    (o_mem_req && !o_mem_we && o_mem_addr == $past(r.base) + smc_pkg::BASE_FIELD_OFF))
    else $error("resume did not read base field");

endmodule

// file: verification/test_smc_control.sv
// self-checking bench for the save-map entry and resume control
`timescale 1ns/100ps
module test_smc_control;
  logic        i_clock, i_rst_n, i_smi_req, i_intr_req, i_soft_init;
  logic        i_halted, i_halt_exec, i_resume, i_addr32, i_mem_ack;
  logic [15:0] i_seg;
  logic [31:0] i_offset, i_mem_rdata;
  logic        o_mem_req, o_mem_we, o_in_smm, o_smm_halted, o_shutdown;
  logic        o_fpu_real16, o_entry, o_resume, o_halt_refetch;
  logic [3:0]  o_mem_be;
  logic [1:0]  o_resume_action;
  logic [31:0] o_mem_addr, o_mem_wdata, o_handler_addr, o_save_lo, o_save_hi;
  logic [31:0] o_linear_addr, o_base;
  int          bad_count, tests_run;
  // behavioural state: save-map memory, base register, halt flag at entry
  logic [31:0] mem [logic [31:0]];
  logic [31:0] base_m;
  logic        halt_m;

  smc_control dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_smi_req(i_smi_req),
    .i_intr_req(i_intr_req), .i_soft_init(i_soft_init), .i_halted(i_halted),
    .i_halt_exec(i_halt_exec), .i_resume(i_resume), .i_seg(i_seg), .i_offset(i_offset),
    .i_addr32(i_addr32), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_be(o_mem_be),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_in_smm(o_in_smm),
    .o_smm_halted(o_smm_halted), .o_shutdown(o_shutdown), .o_fpu_real16(o_fpu_real16),
    .o_entry(o_entry), .o_handler_addr(o_handler_addr), .o_save_lo(o_save_lo),
    .o_save_hi(o_save_hi), .o_linear_addr(o_linear_addr), .o_base(o_base),
    .o_resume(o_resume), .o_resume_action(o_resume_action),
    .o_halt_refetch(o_halt_refetch));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // memory answers at random latency, one ack per presented access
  always @(negedge i_clock) begin
    i_mem_ack <= 1'b0;
    if (o_mem_req === 1'b1 && ($urandom % 2) == 0) begin
      i_mem_ack <= 1'b1;
      if (!mem.exists(o_mem_addr))
        mem[o_mem_addr] = 32'h0;
      if (o_mem_we === 1'b1) begin
        for (int b = 0; b < 4; b++)
          if (o_mem_be[b])
            mem[o_mem_addr][8*b +: 8] = o_mem_wdata[8*b +: 8];
      end
      i_mem_rdata <= mem[o_mem_addr];
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // wait for the entry (sel 0) or resume (sel 1) pulse, bounded
  task automatic wait_ev(input int sel);
    logic got;
    got = 1'b0;
    for (int k = 0; k < 60 && !got; k++) begin
      @(negedge i_clock);
      got = ((sel == 0) ? o_entry : o_resume) === 1'b1;
    end
    chk("handshake", {31'h0, got}, 32'h1);
  endtask

  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clock);
    i_rst_n = 1'b1;
    base_m = 32'h0003_0000;
    chk("base", o_base, base_m);
    chk("handler", o_handler_addr, base_m + 32'h8000);
  endtask

  task automatic enter(input logic h);
    logic [31:0] rev;
    mem.delete();
    halt_m = h;
    i_halted = h;
    i_smi_req = 1'b1;
    wait_ev(0);
    i_smi_req = 1'b0;
    rev = 32'(smc_pkg::REV_BASE_VERSION) | (32'h1 << smc_pkg::REV_IO_RESTART_BIT)
          | (32'h1 << smc_pkg::REV_RELOC_BIT);
    chk("rev id", mem[base_m + 32'h7EFC], rev);
    chk("halt flag", {31'h0, mem[base_m + 32'h7F00][16]}, {31'h0, h});
    chk("in mode", {31'h0, o_in_smm}, 32'h1);
    // fpu context moves stay with handler software, the fpu format follows the mode
    chk("fpu format", {31'h0, o_fpu_real16}, 32'h1);
    chk("handler", o_handler_addr, base_m + 32'h8000);
    chk("save lo", o_save_lo, base_m + 32'hFE00);
    chk("save hi", o_save_hi, base_m + 32'hFFFF);
    i_halted = 1'b0;
  endtask

  task automatic do_resume(input logic [31:0] nb, input logic f);
    logic [31:0] w;
    logic [1:0]  act;
    w = 32'h0;
    w[16] = f;
    mem[base_m + 32'h7EF8] = nb;
    mem[base_m + 32'h7F00] = w;
    act = halt_m ? (f ? 2'h2 : 2'h1) : 2'h0;
    i_resume = 1'b1;
    @(negedge i_clock);
    i_resume = 1'b0;
    wait_ev(1);
    chk("action", {30'h0, o_resume_action}, {30'h0, act});
    chk("refetch", {31'h0, o_halt_refetch}, {31'h0, act == 2'h2});
    base_m = nb;
    chk("base", o_base, base_m);
    @(negedge i_clock);
    chk("left mode", {31'h0, o_in_smm}, 32'h0);
    chk("handler", o_handler_addr, base_m + 32'h8000);
  endtask

  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  initial begin
    logic [31:0] lin;
    {i_rst_n, i_smi_req, i_intr_req, i_soft_init, i_halted} = '0;
    {i_halt_exec, i_resume, i_addr32, i_mem_ack} = '0;
    i_seg = 16'h0000;
    i_offset = 32'h0;
    i_mem_rdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(32'hf4df13a4));
    @(negedge i_clock);
    do_reset();
    // flag combinations: 0/0, 1/1, 1/0, relocating each time
    // a flag found 0 at entry is never raised before resume
    // one core only, so any base is distinct
    enter(1'b0);
    do_resume(($urandom & 32'h00FF_8000) | 32'h0010_0000, 1'b0);
    enter(1'b1);
    do_resume($urandom & 32'h00FF_FFF0, 1'b1);
    enter(1'b1);
    do_resume(32'h0003_0000, 1'b0);
    // halt inside the mode, only the maskable interrupt ends it
    // halt issued only as if interrupts were enabled first
    enter(1'b0);
    i_halt_exec = 1'b1;
    @(negedge i_clock);
    i_halt_exec = 1'b0;
    i_smi_req = 1'b1;
    repeat (6) @(negedge i_clock);
    chk("halted", {31'h0, o_smm_halted}, 32'h1);
    i_smi_req = 1'b0;
    i_intr_req = 1'b1;
    repeat (4) @(negedge i_clock);
    i_intr_req = 1'b0;
    chk("halted", {31'h0, o_smm_halted}, 32'h0);
    chk("in mode", {31'h0, o_in_smm}, 32'h1);
    do_resume(32'h0004_8000, 1'b0);
    // soft init keeps the relocated base, hard reset restores it
    enter(1'b0);
    i_soft_init = 1'b1;
    @(negedge i_clock);
    i_soft_init = 1'b0;
    @(negedge i_clock);
    chk("in mode", {31'h0, o_in_smm}, 32'h0);
    chk("base", o_base, base_m);
    do_reset();
    // real-mode segment forming, with and without the size override
    for (int n = 0; n < 16; n++) begin
      i_seg = 16'($urandom);
      i_offset = $urandom;
      i_addr32 = 1'(n % 2);
      @(negedge i_clock);
      if (i_addr32)
        lin = {12'h0, i_seg, 4'h0} + i_offset;
      else
        lin = ({12'h0, i_seg, 4'h0} + {16'h0, i_offset[15:0]}) & 32'h000F_FFFF;
      chk("linear", o_linear_addr, lin);
    end
    chk("shutdown", {31'h0, o_shutdown}, 32'h0);
    end_sim();
  end
endmodule
